// ==== rtl/display_link_pkg.sv ====
package display_link_pkg;
	`include "display_link_regs.svh"

	typedef logic [`DL_WORD_BITS-1:0] pixel_word_t;
	typedef logic [`DL_SLOTS-1:0]     lane_bits_t;
	typedef logic [2:0]               slot_t;

	typedef enum logic {
		LS_LOCKING,
		LS_RUN
	} link_state_e;

	typedef enum logic {
		XS_IDLE,
		XS_WAIT
	} xfer_state_e;
endpackage : display_link_pkg

// ==== rtl/display_link_regs.svh ====
`ifndef DISPLAY_LINK_REGS_SVH
`define DISPLAY_LINK_REGS_SVH

`define DL_LANES             4
`define DL_SLOTS             7
`define DL_WORD_BITS         28
`define DL_PAIRS             5
`define DL_NARROW_LANE       3
`define DL_SLOT_FIRST        3'h0
`define DL_SLOT_LAST         3'h6
`define DL_FWD_CLK_PATTERN   7'h0f
`define DL_FIFO_DEPTH        4
`define DL_LOCK_TIME_NS      1000
`define DL_BIT_CLK_PERIOD_NS 48
`define DL_LOCK_CYCLES       ((`DL_LOCK_TIME_NS + `DL_BIT_CLK_PERIOD_NS - 1) / `DL_BIT_CLK_PERIOD_NS)

`endif

// ==== rtl/display_link_serializer_28to4.sv ====
`timescale 1ns/1ps
`include "display_link_regs.svh"
module display_link_serializer_28to4
	import display_link_pkg::*;
#(
	parameter int WORD_BITS   = `DL_WORD_BITS,
	parameter int FIFO_DEPTH  = `DL_FIFO_DEPTH,
	parameter int LOCK_CYCLES = `DL_LOCK_CYCLES
) (
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_sys_rst,
	input  wire logic                 i_clk_bit,
	input  wire logic                 i_word_clock_in,
	input  wire logic                 i_capture_edge_select,
	input  wire logic                 i_shutdown_clear_n,
	input  wire logic                 i_narrow_link,
	input  wire logic [WORD_BITS-1:0] i_parallel_pixel_bits,
	output logic                      o_serial_lane0_pos,
	output logic                      o_serial_lane0_neg,
	output logic                      o_serial_lane1_pos,
	output logic                      o_serial_lane1_neg,
	output logic                      o_serial_lane2_pos,
	output logic                      o_serial_lane2_neg,
	output logic                      o_serial_lane3_pos,
	output logic                      o_serial_lane3_neg,
	output logic                      o_forwarded_clock_pos,
	output logic                      o_forwarded_clock_neg,
	output logic [`DL_PAIRS-1:0]      o_pair_drive_en,
	output logic                      o_capture_overrun
);
	localparam int CW = $clog2(LOCK_CYCLES + 1);
	localparam logic [`DL_SLOTS-1:0] FWD_PATTERN = `DL_FWD_CLK_PATTERN;

	if (WORD_BITS != `DL_LANES * `DL_SLOTS || LOCK_CYCLES < 1) begin : g_param_check
		$error("word width must fill all lanes and lock count must be at least one");
	end

	// fixed mapping: lane k, slot s carries bit 7k+s
	function automatic lane_bits_t lane_slice(input pixel_word_t w, input int k);
		lane_slice = w[k*`DL_SLOTS +: `DL_SLOTS];
	endfunction : lane_slice

	// ---------------- system domain: capture and hand-off ----------------
	logic        wclk_s1, wclk_s2, wclk_s3;
	logic        sel_s1, sel_s2;
	logic        sd_s1, sd_s2;
	logic        ack_s1, ack_s2;
	pixel_word_t pix_s1, pix_s2;
	logic        sys_clear;
	logic        edge_hit;
	logic [2:0]  prime_r; // a cleared chain shows a false edge to a high pin until primed

	pixel_word_t cap_word_r, cap_word_nxt;
	logic        cap_valid_r, cap_valid_nxt;
	logic        overrun_r, overrun_nxt;
	xfer_state_e xs_r, xs_nxt;
	pixel_word_t xfer_word_r, xfer_word_nxt;
	logic        req_tgl_r, req_tgl_nxt;
	logic        ack_tgl_r;

	word_fifo_if #(.WIDTH(WORD_BITS)) fq ();

	word_fifo #(
		.WIDTH (WORD_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_word_fifo (
		.i_clk_sys (i_clk_sys),
		.i_clear   (sys_clear),
		.f         (fq)
	);

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			sd_s1 <= 1'b0;
			sd_s2 <= 1'b0;
		end else begin
			sd_s1 <= i_shutdown_clear_n;
			sd_s2 <= sd_s1;
		end
	end

	assign sys_clear = i_sys_rst || !sd_s2;

	// pixel bits go through the same two stages as the word clock so they stay aligned
	always_ff @(posedge i_clk_sys) begin
		if (sys_clear) begin
			wclk_s1 <= 1'b0;
			wclk_s2 <= 1'b0;
			wclk_s3 <= 1'b0;
			sel_s1  <= 1'b0;
			sel_s2  <= 1'b0;
			ack_s1  <= 1'b0;
			ack_s2  <= 1'b0;
			pix_s1  <= '0;
			pix_s2  <= '0;
			prime_r <= '0;
		end else begin
			wclk_s1 <= i_word_clock_in;
			wclk_s2 <= wclk_s1;
			wclk_s3 <= wclk_s2;
			sel_s1  <= i_capture_edge_select;
			sel_s2  <= sel_s1;
			ack_s1  <= ack_tgl_r;
			ack_s2  <= ack_s1;
			pix_s1  <= i_parallel_pixel_bits;
			pix_s2  <= pix_s1;
			prime_r <= {prime_r[1:0], 1'b1};
		end
	end

	// select high captures on the rising edge, low on the falling edge
	assign edge_hit = prime_r[2] &&
	                  (sel_s2 ? (wclk_s2 && !wclk_s3) : (!wclk_s2 && wclk_s3));

	assign fq.push_data  = cap_word_r;
	assign fq.push_valid = cap_valid_r;
	assign fq.pop_ready  = (xs_r == XS_IDLE);

	always_comb begin
		cap_word_nxt  = cap_word_r;
		cap_valid_nxt = edge_hit;
		overrun_nxt   = overrun_r || (cap_valid_r && !fq.push_ready);
		xs_nxt        = xs_r;
		xfer_word_nxt = xfer_word_r;
		req_tgl_nxt   = req_tgl_r;
		if (edge_hit) begin
			cap_word_nxt = pix_s2;
		end
		case (xs_r)
			XS_IDLE: begin
				if (fq.pop_valid) begin
					xfer_word_nxt = fq.pop_data;
					req_tgl_nxt   = !req_tgl_r;
					xs_nxt        = XS_WAIT;
				end
			end
			XS_WAIT: begin
				// word must hold still until the link side has echoed the toggle
				if (ack_s2 == req_tgl_r) begin
					xs_nxt = XS_IDLE;
				end
			end
			default: xs_nxt = XS_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (sys_clear) begin
			cap_word_r  <= '0;
			cap_valid_r <= 1'b0;
			overrun_r   <= 1'b0;
			xs_r        <= XS_IDLE;
			xfer_word_r <= '0;
			req_tgl_r   <= 1'b0;
		end else begin
			cap_word_r  <= cap_word_nxt;
			cap_valid_r <= cap_valid_nxt;
			overrun_r   <= overrun_nxt;
			xs_r        <= xs_nxt;
			xfer_word_r <= xfer_word_nxt;
			req_tgl_r   <= req_tgl_nxt;
		end
	end

	assign o_capture_overrun = overrun_r;

	// ---------------- link domain: lock, shift and drive ----------------
	logic        lrst_s1, lrst_s2;
	logic        req_s1, req_s2;
	logic        narrow_s1, narrow_s2;
	logic        link_rst;
	logic        new_req;

	link_state_e                         ls_r, ls_nxt;
	logic [CW-1:0]                       lock_cnt_r, lock_cnt_nxt;
	slot_t                               slot_r, slot_nxt;
	logic [`DL_LANES-1:0][`DL_SLOTS-1:0] sh_r, sh_nxt;
	pixel_word_t                         pend_word_r, pend_word_nxt;
	logic                                pend_valid_r, pend_valid_nxt;
	logic                                ack_tgl_nxt;
	logic [`DL_LANES-1:0]                lane_r, lane_nxt;
	logic [`DL_LANES-1:0]                lane_n_r, lane_n_nxt;
	logic                                fwd_r, fwd_nxt;
	logic                                fwd_n_r, fwd_n_nxt;
	logic                                drive_r, drive_nxt;

	// shutdown and system reset both reach the link side through two stages
	always_ff @(posedge i_clk_bit) begin
		lrst_s1 <= i_sys_rst || !i_shutdown_clear_n;
		lrst_s2 <= lrst_s1;
	end

	assign link_rst = lrst_s2;

	always_ff @(posedge i_clk_bit) begin
		if (link_rst) begin
			req_s1    <= 1'b0;
			req_s2    <= 1'b0;
			narrow_s1 <= 1'b0;
			narrow_s2 <= 1'b0;
		end else begin
			req_s1    <= req_tgl_r;
			req_s2    <= req_s1;
			narrow_s1 <= i_narrow_link;
			narrow_s2 <= narrow_s1;
		end
	end

	// a request stays open until echoed and is taken only once the pending word has room
	assign new_req = (req_s2 != ack_tgl_r) &&
	                 ((ls_r != LS_RUN) || !pend_valid_r || (slot_r == `DL_SLOT_LAST));

	always_comb begin
		ls_nxt         = ls_r;
		lock_cnt_nxt   = lock_cnt_r;
		slot_nxt       = slot_r;
		sh_nxt         = sh_r;
		pend_word_nxt  = pend_word_r;
		pend_valid_nxt = pend_valid_r;
		ack_tgl_nxt    = ack_tgl_r;
		case (ls_r)
			LS_LOCKING: begin
				// stand-in for multiplier lock: a fixed wait after shutdown release
				lock_cnt_nxt = lock_cnt_r + {{(CW-1){1'b0}}, 1'b1};
				if (lock_cnt_r == CW'(LOCK_CYCLES - 1)) begin
					ls_nxt = LS_RUN;
				end
			end
			LS_RUN: begin
				if (slot_r == `DL_SLOT_LAST) begin
					slot_nxt       = `DL_SLOT_FIRST;
					pend_valid_nxt = 1'b0;
					for (int k = 0; k < `DL_LANES; k++) begin
						sh_nxt[k] = pend_valid_r ? lane_slice(pend_word_r, k) : '0;
					end
					if (narrow_s2) begin
						sh_nxt[`DL_NARROW_LANE] = '0;
					end
				end else begin
					slot_nxt = slot_r + 3'h1;
					for (int k = 0; k < `DL_LANES; k++) begin
						sh_nxt[k] = sh_r[k] >> 1;
					end
				end
			end
			default: ls_nxt = LS_LOCKING;
		endcase
		// a new word landing in the load cycle wins over the clear of the pending flag
		if (new_req) begin
			ack_tgl_nxt = !ack_tgl_r;
			if (ls_r == LS_RUN) begin
				pend_word_nxt  = xfer_word_r;
				pend_valid_nxt = 1'b1;
			end
		end
	end

	always_comb begin
		for (int k = 0; k < `DL_LANES; k++) begin
			lane_nxt[k]   = (ls_r == LS_RUN) && sh_r[k][0];
			lane_n_nxt[k] = (ls_r == LS_RUN) && !sh_r[k][0];
		end
		fwd_nxt   = (ls_r == LS_RUN) && FWD_PATTERN[slot_r];
		fwd_n_nxt = (ls_r == LS_RUN) && !FWD_PATTERN[slot_r];
		drive_nxt = (ls_r == LS_RUN);
	end

	always_ff @(posedge i_clk_bit) begin
		if (link_rst) begin
			ls_r         <= LS_LOCKING;
			lock_cnt_r   <= '0;
			slot_r       <= `DL_SLOT_LAST;
			sh_r         <= '0;
			pend_word_r  <= '0;
			pend_valid_r <= 1'b0;
			ack_tgl_r    <= 1'b0;
			lane_r       <= '0;
			lane_n_r     <= '0;
			fwd_r        <= 1'b0;
			fwd_n_r      <= 1'b0;
			drive_r      <= 1'b0;
		end else begin
			ls_r         <= ls_nxt;
			lock_cnt_r   <= lock_cnt_nxt;
			slot_r       <= slot_nxt;
			sh_r         <= sh_nxt;
			pend_word_r  <= pend_word_nxt;
			pend_valid_r <= pend_valid_nxt;
			ack_tgl_r    <= ack_tgl_nxt;
			lane_r       <= lane_nxt;
			lane_n_r     <= lane_n_nxt;
			fwd_r        <= fwd_nxt;
			fwd_n_r      <= fwd_n_nxt;
			drive_r      <= drive_nxt;
		end
	end

	assign o_serial_lane0_pos    = lane_r[0];
	assign o_serial_lane0_neg    = lane_n_r[0];
	assign o_serial_lane1_pos    = lane_r[1];
	assign o_serial_lane1_neg    = lane_n_r[1];
	assign o_serial_lane2_pos    = lane_r[2];
	assign o_serial_lane2_neg    = lane_n_r[2];
	assign o_serial_lane3_pos    = lane_r[3];
	assign o_serial_lane3_neg    = lane_n_r[3];
	assign o_forwarded_clock_pos = fwd_r;
	assign o_forwarded_clock_neg = fwd_n_r;
	assign o_pair_drive_en       = {`DL_PAIRS{drive_r}};

	// ---------------- checks ----------------
	sequence s_fwd_rise;
		fwd_r && !$past(fwd_r);
	endsequence

	sequence s_word_load;
		(ls_r == LS_RUN) && (slot_r == `DL_SLOT_LAST);
	endsequence

	a_capture_on_edge: assert property (@(posedge i_clk_sys) disable iff (sys_clear)
		edge_hit |=> (cap_word_r == $past(pix_s2)) && cap_valid_r)
		else $error("captured word differs from sampled pixel bits");

	a_edge_polarity: assert property (@(posedge i_clk_sys) disable iff (sys_clear)
		(prime_r[2] && sel_s2 && wclk_s2 && !wclk_s3) |-> edge_hit)
		else $error("rising edge missed with rising capture selected");

	a_shutdown_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!sd_s2 |=> (cap_word_r == '0) && !cap_valid_r && (xfer_word_r == '0))
		else $error("capture state not cleared under shutdown");

	a_xfer_hold: assert property (@(posedge i_clk_sys) disable iff (sys_clear)
		(xs_r == XS_WAIT) |=> $stable(xfer_word_r))
		else $error("hand-off word changed before acknowledge");

	a_slot_wrap: assert property (@(posedge i_clk_bit) disable iff (link_rst)
		s_word_load |=> (slot_r == `DL_SLOT_FIRST) ##6 (slot_r == `DL_SLOT_LAST))
		else $error("serial word is not seven bit periods long");

	a_lane_shift: assert property (@(posedge i_clk_bit) disable iff (link_rst)
		((ls_r == LS_RUN) && (slot_r != `DL_SLOT_LAST)) |=> (sh_r[0] == ($past(sh_r[0]) >> 1)))
		else $error("lane register did not shift by one");

	a_fwd_period: assert property (@(posedge i_clk_bit) disable iff (link_rst)
		s_fwd_rise |-> ##7 s_fwd_rise)
		else $error("forwarded clock period is not one serial word");

	a_fwd_slot_zero: assert property (@(posedge i_clk_bit) disable iff (link_rst)
		s_fwd_rise |-> ($past(slot_r) == `DL_SLOT_FIRST))
		else $error("forwarded clock rise not aligned to slot zero");

	a_quiet_unlocked: assert property (@(posedge i_clk_bit) disable iff (link_rst)
		(ls_r == LS_LOCKING) |=> !drive_r && (lane_r == '0) && !fwd_r)
		else $error("outputs active before lock");

	a_narrow_lane: assert property (@(posedge i_clk_bit) disable iff (link_rst)
		(narrow_s2 && $past(narrow_s2, 8)) |-> !lane_r[`DL_NARROW_LANE])
		else $error("idle lane carries data in narrow mode");

	a_drive_off: assert property (@(posedge i_clk_bit)
		link_rst |=> !drive_r && (sh_r == '0) && !pend_valid_r)
		else $error("drivers or shift registers active in shutdown");
endmodule : display_link_serializer_28to4

// ==== rtl/word_fifo.sv ====
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 4
) (
	input wire logic  i_clk_sys,
	input wire logic  i_clear,
	word_fifo_if.fifo f
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
		$error("word_fifo depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_r   [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [AW:0]      wr_r;
	logic [AW:0]      wr_nxt;
	logic [AW:0]      rd_r;
	logic [AW:0]      rd_nxt;
	logic             full;
	logic             empty;

	// one extra pointer bit tells full from empty without a counter
	assign full         = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
	assign empty        = (wr_r == rd_r);
	assign f.push_ready = !full;
	assign f.pop_valid  = !empty;
	assign f.pop_data   = mem_r[rd_r[AW-1:0]];

	always_comb begin
		mem_nxt = mem_r;
		wr_nxt  = wr_r;
		rd_nxt  = rd_r;
		if (f.push_valid && !full) begin
			mem_nxt[wr_r[AW-1:0]] = f.push_data;
			wr_nxt                = wr_r + {{AW{1'b0}}, 1'b1};
		end
		if (f.pop_ready && !empty) begin
			rd_nxt = rd_r + {{AW{1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_clear) begin
			wr_r <= '0;
			rd_r <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else begin
			wr_r  <= wr_nxt;
			rd_r  <= rd_nxt;
			mem_r <= mem_nxt;
		end
	end
endmodule : word_fifo

// ==== rtl/word_fifo_if.sv ====
`timescale 1ns/1ps
interface word_fifo_if #(
	parameter int WIDTH = 28
);
	logic [WIDTH-1:0] push_data;
	logic             push_valid;
	logic             push_ready;
	logic [WIDTH-1:0] pop_data;
	logic             pop_valid;
	logic             pop_ready;

	modport fifo (
		input  push_data,
		input  push_valid,
		output push_ready,
		output pop_data,
		output pop_valid,
		input  pop_ready
	);
	modport user (
		output push_data,
		output push_valid,
		input  push_ready,
		input  pop_data,
		input  pop_valid,
		output pop_ready
	);
endinterface : word_fifo_if

// ==== sim/link_receiver_model.sv ====
`timescale 1ns/1ps
module link_receiver_model (
	input  wire logic        i_clk_bit,
	input  wire logic [3:0]  i_lane_pos,
	input  wire logic [3:0]  i_lane_neg,
	input  wire logic        i_fwd_pos,
	input  wire logic        i_fwd_neg,
	input  wire logic [4:0]  i_drive_en,
	output logic      [27:0] o_word,
	output logic             o_word_stb,
	output logic      [15:0] o_bad_count
);
	logic [6:0]  fwd_hist = '0;
	logic [6:0]  lane_hist [4];
	logic [3:0]  gap      = '0;
	logic        framed   = 1'b0;
	logic [15:0] bad      = '0;
	logic [27:0] word     = '0;

	initial begin
		o_word = '0;
		o_word_stb = 1'b0;
		o_bad_count = '0;
		foreach (lane_hist[k]) lane_hist[k] = '0;
	end

	// passive receiver: frames words on the forwarded clock, oldest sample is slot 0
	always @(posedge i_clk_bit) begin
		if (i_drive_en === 5'h1f && {i_lane_neg, i_fwd_neg} !== ~{i_lane_pos, i_fwd_pos}) begin
			bad = bad + 16'h1;
		end
		if (i_drive_en === 5'h00 && {i_lane_pos, i_lane_neg, i_fwd_pos, i_fwd_neg} !== 10'h0) begin
			bad = bad + 16'h1;
		end
		fwd_hist = {i_fwd_pos, fwd_hist[6:1]};
		foreach (lane_hist[k]) lane_hist[k] = {i_lane_pos[k], lane_hist[k][6:1]};
		gap = gap + 4'h1;
		if (i_drive_en !== 5'h1f) begin
			framed = 1'b0;
		end else if (fwd_hist[6] && !fwd_hist[5]) begin
			if (framed && gap != 4'h7) begin
				bad = bad + 16'h1;
			end
			framed = 1'b1;
			gap = '0;
		end
		for (int k = 0; k < 4; k++) begin
			for (int s = 0; s < 7; s++) begin
				word[7*k+s] = lane_hist[k][s];
			end
		end
		o_word_stb  <= framed && fwd_hist == 7'h0f;
		o_word      <= word;
		o_bad_count <= bad;
	end
endmodule : link_receiver_model

// ==== sim/tb_display_link_serializer_28to4.sv ====
`timescale 1ns/1ps
module tb_display_link_serializer_28to4
	import display_link_pkg::*;
;
	logic             clk_sys   = 1'b0;
	logic             clk_bit   = 1'b0;
	logic             sys_rst   = 1'b1;
	logic             wclk      = 1'b0;
	logic             sel       = 1'b1;
	logic             sd_n      = 1'b1;
	logic             narrow    = 1'b0;
	logic             rx_ignore = 1'b0;
	pixel_word_t      pix       = '0;
	wire logic [3:0]  lp;
	wire logic [3:0]  ln;
	wire logic        fp;
	wire logic        fn;
	wire logic [4:0]  den;
	wire logic        ovr;
	wire logic [27:0] rx_word;
	wire logic        rx_stb;
	wire logic [15:0] rx_bad;
	int               fails     = 0;
	int               n_checks  = 0;
	pixel_word_t      expq [$];
	pixel_word_t      pats [6]  = '{28'h0000001, 28'h8000000, 28'haaaaaaa,
	                                28'h5555555, 28'hfffffff, 28'h1234567};

	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		#7;
		forever #24 clk_bit = ~clk_bit;
	end

	display_link_serializer_28to4 #(.LOCK_CYCLES(6)) u_dut (
		.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_clk_bit(clk_bit),
		.i_word_clock_in(wclk), .i_capture_edge_select(sel), .i_shutdown_clear_n(sd_n),
		.i_narrow_link(narrow), .i_parallel_pixel_bits(pix),
		.o_serial_lane0_pos(lp[0]), .o_serial_lane0_neg(ln[0]),
		.o_serial_lane1_pos(lp[1]), .o_serial_lane1_neg(ln[1]),
		.o_serial_lane2_pos(lp[2]), .o_serial_lane2_neg(ln[2]),
		.o_serial_lane3_pos(lp[3]), .o_serial_lane3_neg(ln[3]),
		.o_forwarded_clock_pos(fp), .o_forwarded_clock_neg(fn),
		.o_pair_drive_en(den), .o_capture_overrun(ovr)
	);

	link_receiver_model u_rx (
		.i_clk_bit(clk_bit), .i_lane_pos(lp), .i_lane_neg(ln), .i_fwd_pos(fp),
		.i_fwd_neg(fn), .i_drive_en(den), .o_word(rx_word), .o_word_stb(rx_stb),
		.o_bad_count(rx_bad)
	);

	task automatic chk(input pixel_word_t got, input pixel_word_t exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	// idle words are all zero, so only non-zero words are matched against the queue
	always @(posedge clk_bit) begin
		if (rx_stb === 1'b1 && rx_word !== 28'h0 && !rx_ignore) begin
			chk(rx_word, expq.size() != 0 ? expq.pop_front() : 28'h0);
		end
	end

	task automatic wait_en;
		for (int i = 0; i < 300 && den !== 5'h1f; i++) @(posedge clk_sys);
		chk(pixel_word_t'(den), 28'h1f);
	endtask : wait_en

	// word rate is scaled far below the lock range: the pin is sampled by the system clock
	task automatic drv_word(input pixel_word_t w, input int half, input logic push);
		pixel_word_t e;
		e = narrow ? (w & 28'h01fffff) : w;
		@(posedge clk_sys);
		pix  <= w;
		wclk <= ~sel;
		repeat (half) @(posedge clk_sys);
		wclk <= sel;
		if (push && e != '0) expq.push_back(e);
		repeat (half) @(posedge clk_sys);
	endtask : drv_word

	task automatic t_words(input logic s, input logic n);
		@(posedge clk_sys);
		sel    <= s;
		narrow <= n;
		repeat (20) @(posedge clk_sys);
		foreach (pats[i]) drv_word(pats[i], 8, 1'b1);
		for (int i = 0; i < 400 && expq.size() != 0; i++) @(posedge clk_sys);
		chk(pixel_word_t'(expq.size()), '0);
		$display("test words sel=%0d narrow=%0d done", s, n);
	endtask : t_words

	task automatic t_overrun;
		rx_ignore = 1'b1;
		for (int i = 0; i < 30; i++) drv_word(pats[i%6], 4, 1'b0);
		chk(pixel_word_t'(ovr), 28'h1);
		@(posedge clk_sys);
		sd_n <= 1'b0;
		repeat (20) @(posedge clk_sys);
		chk(pixel_word_t'({ovr, den, fp, fn, lp, ln}), '0);
		sd_n <= 1'b1;
		repeat (5) @(posedge clk_bit);
		#1 chk(pixel_word_t'(den), '0);
		wait_en();
		rx_ignore = 1'b0;
		$display("test overrun and shutdown done");
	endtask : t_overrun

	initial begin
		repeat (19) @(posedge clk_sys);
		#1 chk(pixel_word_t'({den, fp, lp}), '0);
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		wait_en();
		$display("test startup done");
		t_words(1'b1, 1'b0);
		t_words(1'b0, 1'b0);
		t_words(1'b1, 1'b1);
		t_overrun();
		t_words(1'b1, 1'b0);
		chk(pixel_word_t'(rx_bad), '0);
		end_sim();
	end

	initial begin
		#300000;
		fails++;
		$display("watchdog expired at %0t", $time);
		end_sim();
	end
endmodule : tb_display_link_serializer_28to4
